/* design/dtc_defs.svh */
// Constants for the tag bus command decoder
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
`define DTC_CMD_READ 4'h0
`define DTC_CMD_WRITE 4'h1
`define DTC_CMD_RQSTAT 4'h2
`define DTC_CMD_RQATTN 4'h3
`define DTC_CMD_DISC 4'h4
`define DTC_CMD_CLEAR 4'h5
`define DTC_CMD_RQSECT 4'h6
`define DTC_CMD_SEEK 4'h8
`define DTC_CMD_ADDR 4'h9
`define DTC_CMD_UNIT 4'ha
`define DTC_CMD_RECAL 4'hb
`define DTC_CMD_XMIT 4'hc
`define DTC_CMD_OFFSET 4'hd
`define DTC_CMD_CLSTAT 4'he
`define DTC_CMD_SPARE_LO 4'h7
`define DTC_CMD_SPARE_HI 4'hf
`define DTC_MAX_CYL 9'h19a
`define DTC_CLS_ATTN 0
`define DTC_CLS_FIRST 1
`define DTC_OFS_SIGN 7
`define DTC_ATT_SEEK 0
`define DTC_ATT_ILL 1
`define DTC_ATT_RET 2
`define DTC_REG_CTRL 4'h0
`define DTC_REG_STATUS 4'h4
`define DTC_REG_ISTAT 4'h8
`define DTC_REG_IMASK 4'hc
`endif

/* design/dtc_pkg.sv */
// Types for the tag bus command decoder
package dtc_pkg;
   typedef enum logic [1:0] {DTC_IDLE = 2'b00, DTC_LAUNCH = 2'b01, DTC_MOVING = 2'b11} dtc_seek_t;
   typedef struct packed {
      logic [5:0] sector;
      logic protect;
      logic fault;
      logic format_mode;
      logic drive_type;
      logic sector_compare;
      logic head1_sel;
      logic head2_sel;
      logic heads_settled;
      logic heads_moved;
      logic emergency_retract;
   } dtc_sense_t;
   typedef struct packed {
      logic [8:0] cylinder;
      logic seek_go;
      logic [6:0] offset;
      logic [5:0] sector_addr;
      logic [1:0] head_id;
      logic [5:0] xmit_sector;
      logic xmit_go;
   } dtc_motion_t;
   typedef struct packed {
      logic strobe_d;
      logic settled_d;
      logic moved_d;
      logic retract_d;
      logic selected;
      dtc_seek_t seek_state;
      logic illegal_pend;
      logic seek_check;
      logic first_status;
      logic drive_ready;
      dtc_motion_t motion;
      logic [10:0] ctl_out;
      logic ctl_oe_n;
      logic attention_line;
      logic [31:0] rdata;
      logic [2:0] unit_sel;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
   } dtc_state_t;
endpackage

/* design/dtc_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module dtc_sync #(parameter int W = 1) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // dtc_sync

/* design/dtc_attention.sv */
// The three attention flip-flops
`timescale 1ns/100ps
`include "dtc_defs.svh"
module dtc_attention (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Events
   input wire logic set_seek,
   input wire logic set_illegal,
   input wire logic set_retract,
   input wire logic clr_all,
   input wire logic clr_moved,
   // Flags
   output logic [2:0] flags
);
   logic [2:0] next_flags;
   logic [2:0] sets;
   always_comb begin
      sets = {set_retract, set_illegal, set_seek};
      next_flags = flags;
      if (clr_all) begin
         next_flags = 3'h0;
      end
      if (clr_moved) begin
         next_flags[`DTC_ATT_SEEK] = 1'b0;
         next_flags[`DTC_ATT_RET] = 1'b0;
      end
      // A set in the same cycle as a clear wins
      next_flags = next_flags | sets;
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flags <= 3'h0;
      end else begin
         flags <= next_flags;
      end
   end
endmodule // dtc_attention

/* design/dtc_drive.sv */
// Drive-side tag bus command decoder with attention logic
`timescale 1ns/100ps
`include "dtc_defs.svh"
module dtc_drive (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   // Tag and control bus pins
   input wire logic [3:0] tag_bus,
   input wire logic strobe,
   input wire logic [10:0] ctl_in,
   output logic [10:0] ctl_out,
   output logic ctl_oe_n,
   // Drive mechanics
   input wire dtc_pkg::dtc_sense_t sense,
   output dtc_pkg::dtc_motion_t motion,
   output logic attention_line,
   output logic drive_ready_line
);
   import dtc_pkg::*;

   function automatic logic reads_status(input logic [3:0] c);
      return c == `DTC_CMD_READ || c == `DTC_CMD_WRITE || c == `DTC_CMD_RQSTAT;
   endfunction

   //////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   dtc_state_t st;
   dtc_state_t next_st;
   dtc_sense_t sense_s;
   logic [3:0] tag_s;
   logic strb_s;
   logic [10:0] ctl_s;
   logic [2:0] flags;
   logic set_seek;
   logic set_ill;
   logic set_ret;
   logic clr_all;
   logic clr_moved;
   logic [10:0] stat_word;
   logic [10:0] sect_word;
   logic strb_rise;
   logic strb_fall;
   logic attn_now;

   dtc_sync #(.W($bits(dtc_sense_t))) u_sync_sense (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .d(sense),
      .q(sense_s)
   );
   dtc_sync #(.W(16)) u_sync_bus (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .d({strobe, tag_bus, ctl_in}),
      .q({strb_s, tag_s, ctl_s})
   );
   dtc_attention u_attn (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_seek(set_seek),
      .set_illegal(set_ill),
      .set_retract(set_ret),
      .clr_all(clr_all),
      .clr_moved(clr_moved),
      .flags(flags)
   );

   //////////////////////////////////////////////////////////////////////////////////
   // Event detection
   assign strb_rise = strb_s & ~st.strobe_d;
   assign strb_fall = ~strb_s & st.strobe_d;
   assign attn_now = |flags;
   assign set_seek = st.seek_state == DTC_MOVING && sense_s.heads_settled && !st.settled_d;
   assign set_ill = strb_fall && st.illegal_pend;
   assign set_ret = sense_s.emergency_retract && !st.retract_d;
   assign clr_moved = sense_s.heads_moved && !st.moved_d;
   assign clr_all = strb_rise && tag_s == `DTC_CMD_CLSTAT && ctl_s[`DTC_CLS_ATTN];
   // Answer words; access ready only while no seek is in flight
   assign stat_word = {sense_s.drive_type, 1'b0, sense_s.sector_compare, attn_now, sense_s.protect,
                       sense_s.format_mode, sense_s.fault, st.first_status, st.seek_check,
                       st.drive_ready, sense_s.heads_settled && st.seek_state == DTC_IDLE};
   assign sect_word = {sense_s.drive_type, sense_s.head2_sel, sense_s.head1_sel, attn_now,
                       sense_s.protect, sense_s.sector};

   //////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_st = st;
      next_st.strobe_d = strb_s;
      next_st.settled_d = sense_s.heads_settled;
      next_st.moved_d = sense_s.heads_moved;
      next_st.retract_d = sense_s.emergency_retract;
      next_st.motion.seek_go = 1'b0;
      next_st.motion.xmit_go = 1'b0;
      // Illegal cylinder flag waits for the strobe to fall
      if (strb_fall) begin
         next_st.illegal_pend = 1'b0;
      end
      // Command execution on the strobe leading edge
      if (strb_rise) begin
         case (tag_s)
            `DTC_CMD_SEEK: begin
               if (ctl_s[8:0] > `DTC_MAX_CYL) begin
                  next_st.illegal_pend = 1'b1;
                  next_st.seek_check = 1'b1;
               end else begin
                  next_st.motion.cylinder = ctl_s[8:0];
                  next_st.seek_state = DTC_LAUNCH;
                  next_st.seek_check = 1'b0;
                  next_st.motion.offset = 7'h00;
               end
            end
            `DTC_CMD_RECAL: begin
               next_st.motion.cylinder = 9'h000;
               next_st.seek_state = DTC_LAUNCH;
               next_st.seek_check = 1'b0;
               next_st.motion.offset = 7'h00;
            end
            `DTC_CMD_ADDR: begin
               next_st.motion.sector_addr = ctl_s[5:0];
               next_st.motion.head_id = ctl_s[9:8];
            end
            `DTC_CMD_UNIT: next_st.selected = ctl_s[2:0] == st.unit_sel;
            `DTC_CMD_DISC: next_st.selected = 1'b0;
            `DTC_CMD_XMIT: begin
               next_st.motion.xmit_sector = ctl_s[5:0];
               next_st.motion.xmit_go = 1'b1;
            end
            `DTC_CMD_OFFSET: next_st.motion.offset = {ctl_s[`DTC_OFS_SIGN], ctl_s[5:0]};
            `DTC_CMD_CLSTAT: begin
               if (ctl_s[`DTC_CLS_FIRST]) begin
                  next_st.first_status = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Head positioning sequence
      case (st.seek_state)
         DTC_LAUNCH: begin
            next_st.motion.seek_go = 1'b1;
            next_st.seek_state = DTC_MOVING;
         end
         DTC_MOVING: begin
            if (set_seek) begin
               next_st.seek_state = DTC_IDLE;
               next_st.drive_ready = 1'b1;
            end
         end
         default: ;
      endcase
      if (sense_s.emergency_retract) begin
         next_st.drive_ready = 1'b0;
         next_st.seek_state = DTC_IDLE;
      end
      // Control bus answer, held while the strobe stays high
      next_st.ctl_out = 11'h000;
      next_st.ctl_oe_n = 1'b1;
      if (strb_s) begin
         if (reads_status(tag_s) && st.selected) begin
            next_st.ctl_out = stat_word;
            next_st.ctl_oe_n = 1'b0;
         end else if (tag_s == `DTC_CMD_RQSECT && st.selected) begin
            next_st.ctl_out = sect_word;
            next_st.ctl_oe_n = 1'b0;
         end else if (tag_s == `DTC_CMD_RQATTN && attn_now) begin
            next_st.ctl_out = 11'h001 << st.unit_sel;
            next_st.ctl_oe_n = 1'b0;
         end
      end
      next_st.attention_line = attn_now;
      // Register port
      next_st.rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            `DTC_REG_CTRL: next_st.rdata = {29'h0, st.unit_sel};
            `DTC_REG_STATUS: next_st.rdata = {16'h0, st.motion.cylinder[7:0], 1'b0, st.seek_check,
                                              st.first_status, st.drive_ready, st.selected, flags};
            `DTC_REG_ISTAT: next_st.rdata = {29'h0, st.irq_stat};
            `DTC_REG_IMASK: next_st.rdata = {29'h0, st.irq_mask};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
      if (reg_wr) begin
         case (reg_addr)
            `DTC_REG_CTRL: next_st.unit_sel = reg_wdata[2:0];
            `DTC_REG_ISTAT: next_st.irq_stat = st.irq_stat & ~reg_wdata[2:0];
            `DTC_REG_IMASK: next_st.irq_mask = reg_wdata[2:0];
            default: ;
         endcase
      end
      // Events latch after the clear, so a set beats a same-cycle write of one
      next_st.irq_stat = next_st.irq_stat | {set_ret, set_ill, set_seek};
      next_st.irq = |(next_st.irq_stat & st.irq_mask);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
         st.first_status <= 1'b1;
         st.ctl_oe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign irq = st.irq;
   assign ctl_out = st.ctl_out;
   assign ctl_oe_n = st.ctl_oe_n;
   assign motion = st.motion;
   assign attention_line = st.attention_line;
   assign drive_ready_line = st.drive_ready;

   //////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   a_status_answer: assert property (strb_s && reads_status(tag_s) && st.selected |=>
      !ctl_oe_n && ctl_out == $past(stat_word)) else $error("status answer wrong");
   a_poll_bit: assert property (strb_s && tag_s == `DTC_CMD_RQATTN && attn_now && !reads_status(tag_s) |=>
      !ctl_oe_n && ctl_out == 11'h001 << $past(st.unit_sel)) else $error("poll bit wrong");
   a_poll_quiet: assert property (strb_s && tag_s == `DTC_CMD_RQATTN && !attn_now |=> ctl_oe_n)
      else $error("poll answered without attention");
   a_sector_answer: assert property (strb_s && tag_s == `DTC_CMD_RQSECT && st.selected |=>
      ctl_out[5:0] == $past(sense_s.sector) && ctl_out[7] == $past(attn_now)) else $error("sector answer wrong");
   a_attn_line: assert property (##1 attention_line == $past(attn_now)) else $error("attention line mismatch");
   a_moved_clear: assert property (clr_moved && !set_seek && !set_ret |=>
      !flags[`DTC_ATT_SEEK] && !flags[`DTC_ATT_RET]) else $error("flags not cleared on move");
   a_seek_done: assert property (set_seek |=> flags[`DTC_ATT_SEEK] && st.seek_state == DTC_IDLE)
      else $error("seek complete not flagged");
   a_illegal_noseek: assert property (strb_rise && tag_s == `DTC_CMD_SEEK && ctl_s[8:0] > `DTC_MAX_CYL
      && st.seek_state == DTC_IDLE |=> st.seek_state == DTC_IDLE && st.seek_check) else $error("illegal seek moved");
   a_illegal_flag: assert property (strb_fall && st.illegal_pend |=> flags[`DTC_ATT_ILL])
      else $error("illegal cylinder not flagged");
   a_retract_fault: assert property (set_ret |=> !drive_ready_line && flags[`DTC_ATT_RET])
      else $error("retract not reported");
   a_clear_attn: assert property (clr_all && !set_seek && !set_ill && !set_ret |=> flags == 3'h0)
      else $error("clear status failed");
   a_unselected: assert property (strb_s && reads_status(tag_s) && !st.selected |=> ctl_oe_n)
      else $error("unselected drive answered");
   // Motion fields set by the commands, and the seek launch
   a_seek_load: assert property (strb_rise && tag_s == `DTC_CMD_SEEK && ctl_s[8:0] <= `DTC_MAX_CYL |=>
      motion.cylinder == $past(ctl_s[8:0]) && motion.offset == 7'h00) else $error("seek fields wrong");
   a_seek_launch: assert property (st.seek_state == DTC_LAUNCH && !sense_s.emergency_retract |=>
      motion.seek_go && st.seek_state == DTC_MOVING) else $error("seek not launched");
   a_recal_home: assert property (strb_rise && tag_s == `DTC_CMD_RECAL |=>
      motion.cylinder == 9'h000 && motion.offset == 7'h00) else $error("recalibrate target wrong");
   a_addr_fields: assert property (strb_rise && tag_s == `DTC_CMD_ADDR |=>
      motion.sector_addr == $past(ctl_s[5:0]) && motion.head_id == $past(ctl_s[9:8]))
      else $error("address fields wrong");
   a_xmit_go: assert property (strb_rise && tag_s == `DTC_CMD_XMIT |=>
      motion.xmit_go && motion.xmit_sector == $past(ctl_s[5:0])) else $error("transmit fields wrong");
   a_offset_load: assert property (strb_rise && tag_s == `DTC_CMD_OFFSET |=>
      motion.offset == {$past(ctl_s[`DTC_OFS_SIGN]), $past(ctl_s[5:0])}) else $error("offset wrong");
   // Selection, unused codes and fault handling
   a_unit_match: assert property (strb_rise && tag_s == `DTC_CMD_UNIT && ctl_s[2:0] == st.unit_sel |=>
      st.selected) else $error("unit not selected");
   a_first_clear: assert property (strb_rise && tag_s == `DTC_CMD_CLSTAT && ctl_s[`DTC_CLS_FIRST] |=>
      !st.first_status) else $error("first status not cleared");
   a_spare_quiet: assert property (strb_s && (tag_s == `DTC_CMD_SPARE_LO ||
      tag_s == `DTC_CMD_SPARE_HI) |=> ctl_oe_n)
      else $error("unused code answered");
   a_ready_set: assert property (set_seek && !sense_s.emergency_retract |=> drive_ready_line)
      else $error("drive ready not set");
   a_retract_idle: assert property (sense_s.emergency_retract |=>
      st.seek_state == DTC_IDLE && !drive_ready_line) else $error("retract did not stop seek");

   c_seek_done: cover property (set_seek);
   c_illegal: cover property (set_ill);
   c_poll: cover property (!ctl_oe_n && $past(tag_s) == `DTC_CMD_RQATTN);
   c_retract: cover property (set_ret);
   c_sector: cover property (!ctl_oe_n && $past(tag_s) == `DTC_CMD_RQSECT);
endmodule // dtc_drive

/* dv/dtc_ctrl_model.sv */
// Disc controller model on the tag and control buses
`timescale 1ns/100ps
module dtc_ctrl_model (
   // Clock
   input wire logic clk_sys,
   // Drive side of the control bus
   input wire logic [10:0] ctl_out,
   input wire logic ctl_oe_n,
   // Controller pins
   output logic [3:0] tag_bus,
   output logic strobe,
   output logic [10:0] ctl_in
);
   logic [10:0] drv = 11'h000;
   logic drv_en = 1'b0;
   logic [10:0] idle = 11'h2a5;
   logic [10:0] ans;
   logic ans_oe;
   initial begin
      tag_bus = 4'h0;
      strobe = 1'b0;
   end
   // A released bus toggles so a stale value never passes
   always @(posedge clk_sys) idle <= ~idle;
   always_comb ctl_in = !ctl_oe_n ? ctl_out : (drv_en ? drv : idle);
   // Tag and data held for the whole strobe, then a quiet gap
   task automatic issue(input logic [3:0] cmd, input logic [10:0] data, input logic en);
      @(posedge clk_sys);
      tag_bus <= cmd;
      drv <= data;
      drv_en <= en;
      strobe <= 1'b1;
      repeat (7) @(posedge clk_sys);
      ans = ctl_in;
      ans_oe = !ctl_oe_n;
      strobe <= 1'b0;
      drv_en <= 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask
endmodule // dtc_ctrl_model

/* dv/tb.sv */
// Self-checking bench for the tag bus command decoder
`timescale 1ns/100ps
`include "dtc_defs.svh"
module tb;
   import dtc_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic irq, ctl_oe_n, attention_line, drive_ready_line, strobe;
   logic [3:0] tag_bus;
   logic [10:0] ctl_in, ctl_out;
   dtc_sense_t sense = '0;
   dtc_motion_t motion;
   int err_total = 0;
   int total_checks = 0;
   logic [15:0] lf = 16'h002e;
   logic [2:0] unit;
   logic [8:0] cyl;
   logic [3:0] quiet [6] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'hf};
   always #4 clk_sys = ~clk_sys;
   dtc_drive DUT (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .tag_bus(tag_bus),
      .strobe(strobe), .ctl_in(ctl_in), .ctl_out(ctl_out), .ctl_oe_n(ctl_oe_n), .sense(sense),
      .motion(motion), .attention_line(attention_line), .drive_ready_line(drive_ready_line));
   dtc_ctrl_model ctrl (.clk_sys(clk_sys), .ctl_out(ctl_out), .ctl_oe_n(ctl_oe_n),
      .tag_bus(tag_bus), .strobe(strobe), .ctl_in(ctl_in));
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [10:0] stat_w(input logic rdy, input logic chkb, input logic first,
         input logic attn);
      return {sense.drive_type, 1'b0, sense.sector_compare, attn, sense.protect, sense.format_mode,
         sense.fault, first, chkb, rdy, sense.heads_settled};
   endfunction
   function automatic logic [10:0] sect_w(input logic attn);
      return {sense.drive_type, sense.head2_sel, sense.head1_sel, attn, sense.protect, sense.sector};
   endfunction
   ////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      total_checks++;
      if (((got ^ exp) & m) !== 32'h0) begin
         err_total++;
         $display("MISMATCH at %0t: got %h exp %h", $time, got & m, exp & m);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic chk_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e, m);
   endtask
   task automatic chk_ans(input logic [3:0] c, input logic oe, input logic [10:0] e, input logic [10:0] m);
      ctrl.issue(c, 11'h000, 1'b0);
      chk(32'(ctrl.ans_oe), 32'(oe), 32'h1);
      if (oe)
         chk(32'(ctrl.ans), 32'(e), 32'(m));
   endtask
   task automatic wait_att(input logic e);
      for (int i = 0; i < 40 && attention_line !== e; i++)
         @(posedge clk_sys);
      chk(32'(attention_line), 32'(e), 32'h1);
   endtask
   task automatic shuffle();
      lf = nxt(lf);
      sense.sector <= lf[5:0];
      {sense.protect, sense.fault, sense.format_mode, sense.drive_type, sense.sector_compare,
         sense.head1_sel, sense.head2_sel} <= lf[12:6];
      @(posedge clk_sys);
   endtask
   task automatic seek(input logic [8:0] c);
      ctrl.issue(`DTC_CMD_SEEK, {2'b00, c}, 1'b1);
      chk(32'(motion.cylinder), 32'(c), 32'h1ff);
      sense.heads_moved <= 1'b1;
      sense.heads_settled <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk_reg(`DTC_REG_STATUS, 32'h0, 32'h5);
      sense.heads_moved <= 1'b0;
      sense.heads_settled <= 1'b1;
      wait_att(1'b1);
      chk(32'(drive_ready_line), 32'h1, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #100000;
      err_total++;
      summarize();
   end
   initial begin
      sense.heads_settled = 1'b1;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk_reg(`DTC_REG_STATUS, 32'h20, 32'hffffffff);
      wr(`DTC_REG_STATUS, 32'hffff);
      chk_reg(`DTC_REG_STATUS, 32'h20, 32'hffffffff);
      chk_reg(4'h2, 32'h0, 32'hffffffff);
      lf = nxt(lf);
      unit = lf[2:0];
      wr(`DTC_REG_CTRL, 32'(unit));
      chk_reg(`DTC_REG_CTRL, 32'(unit), 32'hffffffff);
      foreach (quiet[i])
         chk_ans(quiet[i], 1'b0, 11'h0, 11'h0);
      $display("done: registers and silence");
      ctrl.issue(`DTC_CMD_UNIT, {8'h00, unit}, 1'b1);
      for (int i = 0; i < 3; i++) begin
         shuffle();
         chk_ans(4'(i), 1'b1, stat_w(1'b0, 1'b0, 1'b1, 1'b0), 11'h7ff);
         chk_ans(`DTC_CMD_RQSECT, 1'b1, sect_w(1'b0), 11'h7ff);
      end
      chk_ans(4'h7, 1'b0, 11'h0, 11'h0);
      chk_ans(`DTC_CMD_RQATTN, 1'b0, 11'h0, 11'h0);
      $display("done: status words");
      wr(`DTC_REG_IMASK, 32'h0);
      ctrl.issue(`DTC_CMD_SEEK, 11'h19b, 1'b1);
      wait_att(1'b1);
      chk_reg(`DTC_REG_STATUS, 32'h6a, 32'h7f);
      chk(32'(irq), 32'h0, 32'h1);
      wr(`DTC_REG_IMASK, 32'h2);
      repeat (3) @(posedge clk_sys);
      chk(32'(irq), 32'h1, 32'h1);
      wr(`DTC_REG_ISTAT, 32'h7);
      repeat (3) @(posedge clk_sys);
      chk(32'(irq), 32'h0, 32'h1);
      chk_ans(`DTC_CMD_READ, 1'b1, stat_w(1'b0, 1'b1, 1'b1, 1'b1), 11'h7ff);
      ctrl.issue(`DTC_CMD_CLSTAT, 11'h003, 1'b1);
      wait_att(1'b0);
      chk_reg(`DTC_REG_STATUS, 32'h08, 32'h3f);
      chk_ans(`DTC_CMD_RQATTN, 1'b0, 11'h0, 11'h0);
      $display("done: illegal seek");
      seek(9'h19a);
      chk_ans(`DTC_CMD_RQATTN, 1'b1, 11'(1 << unit), 11'h7ff);
      chk_ans(`DTC_CMD_READ, 1'b1, stat_w(1'b1, 1'b0, 1'b0, 1'b1), 11'h7ff);
      wr(`DTC_REG_IMASK, 32'h4);
      sense.emergency_retract <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk(32'(drive_ready_line), 32'h0, 32'h1);
      chk_reg(`DTC_REG_STATUS, 32'h4, 32'h4);
      chk(32'(irq), 32'h1, 32'h1);
      sense.emergency_retract <= 1'b0;
      wr(`DTC_REG_ISTAT, 32'h7);
      lf = nxt(lf);
      seek(9'(lf[8:0] % 411));
      $display("done: seeks and retract");
      lf = nxt(lf);
      ctrl.issue(`DTC_CMD_OFFSET, {3'b000, lf[6], 1'b0, lf[5:0]}, 1'b1);
      chk(32'(motion.offset), 32'(lf[6:0]), 32'h7f);
      ctrl.issue(`DTC_CMD_XMIT, {5'h00, lf[12:7]}, 1'b1);
      chk(32'(motion.xmit_sector), 32'(lf[12:7]), 32'h3f);
      ctrl.issue(`DTC_CMD_ADDR, {1'b0, lf[1:0], 2'b00, lf[11:6]}, 1'b1);
      chk(32'({motion.head_id, motion.sector_addr}), 32'({lf[1:0], lf[11:6]}), 32'hff);
      ctrl.issue(`DTC_CMD_RECAL, 11'h7ff, 1'b1);
      chk(32'({motion.cylinder, motion.offset}), 32'h0, 32'hffff);
      $display("done: motion fields");
      summarize();
   end
endmodule // tb
